// ### rtl/qrc_cfg.svh
`ifndef QRC_CFG_SVH
`define QRC_CFG_SVH

// device register indices
`define QRC_DEV_CTRL      2'h0
`define QRC_DEV_LOOP      2'h1
`define QRC_DEV_DRV       2'h2
// controller register offsets
`define QRC_REG_CMD       4'h0
`define QRC_REG_GO        4'h1
`define QRC_REG_RESULT    4'h2
`define QRC_REG_STATUS    4'h3
`define QRC_REG_HEALTH    4'h4
`define QRC_REG_FORCE     4'h5
// go register bit positions
`define QRC_GO_WRITE      0
`define QRC_GO_ADDR_LSB   1
`define QRC_GO_ADDR_MSB   2
// force register bit positions
`define QRC_FORCE_INIT    4
// pin timing figures, ns
`define QRC_T_PW_NS       100
`define QRC_T_SETUP_NS    25
`define QRC_T_HOLD_NS     10
`define QRC_T_DATA_NS     50
`define QRC_CLK_NS        40
// least times round up to whole cycles
`define QRC_PW_CYC    ((`QRC_T_PW_NS + `QRC_CLK_NS - 1) / `QRC_CLK_NS)
`define QRC_SETUP_CYC ((`QRC_T_SETUP_NS + `QRC_CLK_NS - 1) / `QRC_CLK_NS)
`define QRC_HOLD_CYC  ((`QRC_T_HOLD_NS + `QRC_CLK_NS - 1) / `QRC_CLK_NS)
`define QRC_DATA_CYC  ((`QRC_T_DATA_NS + `QRC_CLK_NS - 1) / `QRC_CLK_NS)
// reset values
`define QRC_CMD_RST       8'hFF
`define QRC_FORCE_RST     5'h00
`endif

// ### rtl/qrc_pkg.sv
package qrc_pkg;
	typedef enum logic [1:0] {QRC_IDLE, QRC_SETUP, QRC_PULSE, QRC_HOLD} qrc_state_e;
	typedef struct packed {
		logic       cs;
		logic       rd;
		logic       wr;
		logic [1:0] addr;
		logic [7:0] dout;
		logic       doe;
	} qrc_pins_s;
	typedef struct packed {
		logic [3:0] fault;
		logic [3:0] normal_on;
		logic [3:0] normal_off;
		logic [3:0] tripped;
	} qrc_health_s;
endpackage

// ### rtl/qrc_health.sv
`timescale 1ns/1ns
`default_nettype none
`include "qrc_cfg.svh"
// classifies each switch from control, trip and on/off bits
module qrc_health #(
	parameter int CH = 4
) (
	input  wire logic [7:0]        cmd_i,     // control word last written
	input  wire logic [7:0]        status_i,  // status word last read
	output qrc_pkg::qrc_health_s   health_o   // per-switch conclusion
);
	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : gen_ch
			logic c;
			logic t;
			logic s;
			assign c = cmd_i[2*g];
			assign t = status_i[2*g+1];
			assign s = status_i[2*g];
			assign health_o.tripped[g] = !c && t && s;
			assign health_o.normal_off[g] = c && !t && s;
			assign health_o.normal_on[g] = !c && !t && !s;
			assign health_o.fault[g] = !(health_o.tripped[g] || health_o.normal_off[g]
				|| health_o.normal_on[g]);
		end
	endgenerate
endmodule
`default_nettype wire

// ### rtl/qrc_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "qrc_cfg.svh"
// host controller driving the relay's strobe bus from a software register port
module qrc_host (
	input  wire logic       clk_i,          // 25 MHz clock
	input  wire logic       rst_i,          // async reset, active high
	input  wire logic [3:0] sw_addr_i,      // register address
	input  wire logic [7:0] sw_wdata_i,     // write data
	input  wire logic       sw_we_i,        // write strobe
	input  wire logic       sw_re_i,        // read strobe
	output logic      [7:0] sw_rdata_o,     // read data, cycle after strobe
	output logic            dev_cs_o,       // chip select
	output logic            dev_rd_o,       // read strobe
	output logic            dev_wr_o,       // write strobe
	output logic            reg_sel_lsb_o,  // register select bit 0
	output logic            reg_sel_msb_o,  // register select bit 1
	output logic      [7:0] host_bus_bits_o,  // data bus out
	output logic            host_bus_oe_o,  // data bus enable, high drives
	input  wire logic [7:0] host_bus_bits_i,  // data bus in
	output logic            dev_init_o,     // initialize pin
	output logic      [3:0] dev_force_o,    // per-switch force lines
	output logic            busy_o          // cycle in progress
);
	// timing counts in whole clock cycles; each least time rounds up, so a
	// slower clock only lengthens the cycle and never breaks a minimum
	// the pulse covers both the least strobe width and the read data delay
	// two-bit counters suffice for these figures at this clock rate
	localparam logic [1:0] PW_N = 2'(`QRC_PW_CYC);
	localparam logic [1:0] SU_N = 2'(`QRC_SETUP_CYC);
	localparam logic [1:0] HD_N = 2'(`QRC_HOLD_CYC);
	localparam logic [1:0] DT_N = 2'(`QRC_DATA_CYC);

	// bus pins travel together in one registered struct so they move on one edge
	qrc_pkg::qrc_state_e  state_reg;
	qrc_pkg::qrc_pins_s   pins_reg;
	qrc_pkg::qrc_health_s health;
	logic [1:0]           cnt_reg;
	logic [7:0]           cmd_reg;
	logic [2:0]           go_reg;
	logic [7:0]           result_reg;
	logic [7:0]           status_reg;
	logic [7:0]           last_ctrl_reg;
	logic [4:0]           force_reg;
	logic                 busy_reg;
	logic [7:0]           rdata_reg;
	logic                 start;

	// a go write launches one bus cycle; ignored while busy
	assign start = sw_we_i && sw_addr_i == `QRC_REG_GO && !busy_reg;

	// software-written registers
	// the command word waits here and loads onto the data-out pins when any cycle starts; the bus is driven only for a write
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_reg   <= `QRC_CMD_RST;
			force_reg <= `QRC_FORCE_RST;
			go_reg    <= 3'h0;
		end else if (sw_we_i) begin
			unique case (sw_addr_i)
				`QRC_REG_CMD: cmd_reg <= sw_wdata_i;
				`QRC_REG_FORCE: force_reg <= sw_wdata_i[4:0];
				`QRC_REG_GO: begin
					// a go written while busy is dropped, not queued
					if (!busy_reg)
						go_reg <= sw_wdata_i[2:0];
				end
				default: ;
			endcase
		end
	end

	// bus cycle sequencer: setup, strobe width, hold
	// select, address and data settle one setup count before the strobe and stay
	// one hold count after it, so the device never sees them move under a strobe
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= qrc_pkg::QRC_IDLE;
			cnt_reg   <= 2'h0;
			pins_reg  <= '0;
			busy_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				qrc_pkg::QRC_IDLE: begin
					if (start) begin
						pins_reg.cs   <= 1'b1;
						pins_reg.addr <= {sw_wdata_i[`QRC_GO_ADDR_MSB], sw_wdata_i[`QRC_GO_ADDR_LSB]};
						pins_reg.dout <= cmd_reg;
						pins_reg.doe  <= sw_wdata_i[`QRC_GO_WRITE];
						busy_reg      <= 1'b1;
						cnt_reg       <= SU_N;
						state_reg     <= qrc_pkg::QRC_SETUP;
					end
				end
				qrc_pkg::QRC_SETUP: begin
					if (cnt_reg > 2'h1) begin
						cnt_reg <= cnt_reg - 2'h1;
					end else begin
						pins_reg.wr <= go_reg[`QRC_GO_WRITE];
						pins_reg.rd <= !go_reg[`QRC_GO_WRITE];
						cnt_reg     <= (PW_N > DT_N) ? PW_N : DT_N;
						state_reg   <= qrc_pkg::QRC_PULSE;
					end
				end
				qrc_pkg::QRC_PULSE: begin
					if (cnt_reg > 2'h1) begin
						cnt_reg <= cnt_reg - 2'h1;
					end else begin
						pins_reg.wr <= 1'b0;
						pins_reg.rd <= 1'b0;
						cnt_reg     <= HD_N;
						state_reg   <= qrc_pkg::QRC_HOLD;
					end
				end
				qrc_pkg::QRC_HOLD: begin
					if (cnt_reg > 2'h1) begin
						cnt_reg <= cnt_reg - 2'h1;
					end else begin
						pins_reg.cs  <= 1'b0;
						pins_reg.doe <= 1'b0;
						busy_reg     <= 1'b0;
						state_reg    <= qrc_pkg::QRC_IDLE;
					end
				end
			endcase
		end
	end

	// capture read data while strobe still high, after data delay
	// sampling at the last pulse edge leaves the whole pulse for the data delay;
	// a slower device needs a longer pulse count, not a later sample
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_reg <= 8'h00;
			status_reg <= 8'h00;
		end else if (state_reg == qrc_pkg::QRC_PULSE && cnt_reg == 2'h1 && pins_reg.rd) begin
			result_reg <= host_bus_bits_i;
			if (pins_reg.addr == `QRC_DEV_CTRL)
				status_reg <= host_bus_bits_i;
		end
	end

	// remember last control word sent, for the health check
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			last_ctrl_reg <= `QRC_CMD_RST;
		end else if (state_reg == qrc_pkg::QRC_PULSE && cnt_reg == 2'h1 && pins_reg.wr
			&& pins_reg.addr == `QRC_DEV_CTRL) begin
			last_ctrl_reg <= pins_reg.dout;
		end
	end

	// the health check only knows what this controller wrote; a force-line load
	// or an address-two write changes the latch behind its back
	// classify trip
	qrc_health #(
		.CH(4)
	) u_health (
		.cmd_i    (last_ctrl_reg),
		.status_i (status_reg),
		.health_o (health)
	);

	// software read port, data one cycle after strobe
	// unmapped offsets read as zero, and the port idles at zero between reads
	// so a stale value is never taken for a fresh one
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else if (sw_re_i) begin
			unique case (sw_addr_i)
				`QRC_REG_CMD: rdata_reg <= cmd_reg;
				`QRC_REG_GO: rdata_reg <= {5'h00, go_reg};
				`QRC_REG_RESULT: rdata_reg <= result_reg;
				`QRC_REG_STATUS: rdata_reg <= {7'h00, busy_reg};
				`QRC_REG_HEALTH: rdata_reg <= {health.fault, health.tripped};
				`QRC_REG_FORCE: rdata_reg <= {3'h0, force_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// force lines are software levels, not pulses: they stay applied until
	// cleared, and the initialize pin gates them at the device
	// power-up force via initialize
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dev_init_o  <= 1'b0;
			dev_force_o <= 4'h0;
		end else begin
			dev_init_o  <= force_reg[`QRC_FORCE_INIT];
			dev_force_o <= force_reg[3:0];
		end
	end

	// pins straight from flops
	// no logic between these flops and the pins, so no glitch reaches a strobe
	assign dev_cs_o        = pins_reg.cs;
	assign dev_rd_o        = pins_reg.rd;
	assign dev_wr_o        = pins_reg.wr;
	assign reg_sel_lsb_o   = pins_reg.addr[0];
	assign reg_sel_msb_o   = pins_reg.addr[1];
	assign host_bus_bits_o = pins_reg.dout;
	assign host_bus_oe_o   = pins_reg.doe;
	assign sw_rdata_o      = rdata_reg;
	assign busy_o          = busy_reg;
endmodule
`default_nettype wire

// ### testbench/qrc_relay_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural relay port: control latch, status, loopback, driver readback
module qrc_relay_model #(
	parameter int T_DATA = 50 // data delay, ns
) (
	input  wire logic       cs_i,    // chip select
	input  wire logic       rd_i,    // read strobe
	input  wire logic       wr_i,    // write strobe
	input  wire logic [1:0] sel_i,   // register select
	input  wire logic [7:0] bus_i,   // data bus level
	input  wire logic       init_i,  // force enable
	input  wire logic [3:0] frc_i,   // force lines
	input  wire logic [3:0] trip_i,  // overload per switch
	output logic      [7:0] bus_o    // data driven to host
);
	logic [3:0] ctl = 4'hF; // powers up off
	logic [7:0] loop;
	logic [7:0] val;
	logic [3:0] off;
	always @(negedge wr_i) begin
		if (cs_i && sel_i == 2'h0) ctl = {bus_i[6], bus_i[4], bus_i[2], bus_i[0]};
		else if (cs_i && sel_i == 2'h1) loop = bus_i;
	end
	always @* if (init_i || (cs_i && wr_i && sel_i == 2'h2)) ctl = frc_i;
	assign off = ctl | trip_i;
	always_comb case (sel_i)
		2'h0: val = {trip_i[3], off[3], trip_i[2], off[2], trip_i[1], off[1], trip_i[0], off[0]};
		2'h1: val = loop;
		default: val = {1'b0, ctl[3], 1'b0, ctl[2], 1'b0, ctl[1], 1'b0, ctl[0]};
	endcase
	// a released bus shows the inverse so stale data never matches
	assign #T_DATA bus_o = (cs_i && rd_i) ? val : ~val;
endmodule
`default_nettype wire

// ### testbench/qrc_host_props.sv
`timescale 1ns/1ns
`default_nettype none
// pin protocol checks on the relay bus
module qrc_host_props (
	input wire logic       clk_i,            // clock
	input wire logic       rst_i,            // reset
	input wire logic       dev_cs_o,         // chip select
	input wire logic       dev_rd_o,         // read strobe
	input wire logic       dev_wr_o,         // write strobe
	input wire logic       reg_sel_lsb_o,    // select bit 0
	input wire logic       reg_sel_msb_o,    // select bit 1
	input wire logic [7:0] host_bus_bits_o,  // data out
	input wire logic       host_bus_oe_o,    // data enable
	input wire logic       busy_o            // cycle running
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_wr_needs_cs: assert property (dev_wr_o |-> dev_cs_o) else $error("write without select");
	a_rd_no_drive: assert property (dev_rd_o |-> dev_cs_o && !host_bus_oe_o && !dev_wr_o) else $error("bad read");
	a_wr_setup: assert property ($rose(dev_wr_o) |-> $past(dev_cs_o) && host_bus_oe_o) else $error("no setup");
	a_wr_width: assert property ($rose(dev_wr_o) |-> dev_wr_o[*3] ##1 !dev_wr_o) else $error("write width");
	a_rd_width: assert property ($rose(dev_rd_o) |-> dev_rd_o[*3] ##1 !dev_rd_o) else $error("read width");
	a_data_held: assert property (dev_wr_o && $past(dev_wr_o) |-> $stable(host_bus_bits_o)) else $error("data moved");
	a_sel_held: assert property (dev_cs_o && $past(dev_cs_o) |-> $stable({reg_sel_msb_o, reg_sel_lsb_o})) else $error("select moved");
	a_cycle_len: assert property ($rose(busy_o) |-> busy_o[*5] ##1 !busy_o) else $error("cycle length");
endmodule
bind qrc_host qrc_host_props i_props (
	.clk_i           (clk_i),
	.rst_i           (rst_i),
	.dev_cs_o        (dev_cs_o),
	.dev_rd_o        (dev_rd_o),
	.dev_wr_o        (dev_wr_o),
	.reg_sel_lsb_o   (reg_sel_lsb_o),
	.reg_sel_msb_o   (reg_sel_msb_o),
	.host_bus_bits_o (host_bus_bits_o),
	.host_bus_oe_o   (host_bus_oe_o),
	.busy_o          (busy_o)
);
`default_nettype wire

// ### testbench/test_quad_relay_io_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_quad_relay_io_port;
	logic clk_i = 0, rst_i = 1, sw_we_i = 0, sw_re_i = 0, dev_cs_o, dev_rd_o, dev_wr_o;
	logic reg_sel_lsb_o, reg_sel_msb_o, host_bus_oe_o, dev_init_o, busy_o;
	logic [3:0] sw_addr_i = 4'h0, trip = 4'h0, dev_force_o;
	logic [7:0] sw_wdata_i = 8'h00, sw_rdata_o, host_bus_bits_o, host_bus_bits_i, dev_q;
	logic [31:0] r;
	int num_errors = 0, tests_run = 0;
	// rows: control word, trip lines, status, health
	logic [31:0] rows [5] = '{32'hFF_00_55_00, 32'h00_00_00_00, 32'hAA_00_00_00,
		32'h00_05_33_05, 32'h01_01_03_10};
	always #20 clk_i = ~clk_i;
	// the shared bus wire: host wins while it drives
	assign host_bus_bits_i = host_bus_oe_o ? host_bus_bits_o : dev_q;
	qrc_host i_dut (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.sw_addr_i       (sw_addr_i),
		.sw_wdata_i      (sw_wdata_i),
		.sw_we_i         (sw_we_i),
		.sw_re_i         (sw_re_i),
		.sw_rdata_o      (sw_rdata_o),
		.dev_cs_o        (dev_cs_o),
		.dev_rd_o        (dev_rd_o),
		.dev_wr_o        (dev_wr_o),
		.reg_sel_lsb_o   (reg_sel_lsb_o),
		.reg_sel_msb_o   (reg_sel_msb_o),
		.host_bus_bits_o (host_bus_bits_o),
		.host_bus_oe_o   (host_bus_oe_o),
		.host_bus_bits_i (host_bus_bits_i),
		.dev_init_o      (dev_init_o),
		.dev_force_o     (dev_force_o),
		.busy_o          (busy_o)
	);
	qrc_relay_model i_dev (.cs_i(dev_cs_o), .rd_i(dev_rd_o), .wr_i(dev_wr_o),
		.sel_i({reg_sel_msb_o, reg_sel_lsb_o}), .bus_i(host_bus_bits_i), .init_i(dev_init_o),
		.frc_i(dev_force_o), .trip_i(trip), .bus_o(dev_q));
	task chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task swr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_we_i <= 1'b1;
		@(posedge clk_i);
		sw_we_i <= 1'b0;
	endtask
	task srd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		sw_addr_i <= a;
		sw_re_i <= 1'b1;
		@(posedge clk_i);
		sw_re_i <= 1'b0;
		@(negedge clk_i);
		chk(sw_rdata_o, e);
	endtask
	// start a device cycle and wait, bounded, for it to finish
	task go(input logic [7:0] g);
		swr(4'h1, g);
		repeat (20) begin
			@(negedge clk_i);
			if (busy_o === 1'b0) break;
		end
		// a cycle that never ends counts as a mismatch
		chk({7'h00, busy_o}, 8'h00);
	endtask
	task report_and_stop;
		$display("errors=%0d comparisons=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog far beyond the few hundred cycles the run needs
	initial begin
		#2000000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		srd(4'h0, 8'hFF);
		srd(4'h3, 8'h00);
		srd(4'h7, 8'h00);
		foreach (rows[i]) begin
			r = rows[i];
			trip <= r[19:16];
			swr(4'h0, r[31:24]);
			go(8'h01);
			go(8'h00);
			srd(4'h2, r[15:8]);
			srd(4'h4, r[7:0]);
			go(8'h04);
			srd(4'h2, r[31:24] & 8'h55);
		end
		trip <= 4'h0;
		swr(4'h0, 8'hA5);
		go(8'h03);
		go(8'h02);
		srd(4'h2, 8'hA5);
		// a go while busy is dropped: the register keeps the first order
		swr(4'h1, 8'h03);
		go(8'h00);
		srd(4'h1, 8'h03);
		swr(4'h5, 8'h0F);
		go(8'h00);
		srd(4'h2, 8'h01);
		swr(4'h5, 8'h15);
		swr(4'h5, 8'h00);
		go(8'h00);
		srd(4'h2, 8'h11);
		swr(4'h5, 8'h0A);
		srd(4'h5, 8'h0A);
		go(8'h05);
		srd(4'h1, 8'h05);
		swr(4'h5, 8'h00);
		go(8'h00);
		srd(4'h2, 8'h44);
		// reset while idle: pins, the initialize pin and registers return to reset values
		swr(4'h5, 8'h1F);
		swr(4'h0, 8'h5A);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({dev_cs_o, dev_wr_o, host_bus_oe_o, dev_init_o, busy_o, 3'h0}, 8'h00);
		srd(4'h0, 8'hFF);
		srd(4'h5, 8'h00);
		go(8'h00);
		srd(4'h2, 8'h55);
		report_and_stop();
	end
endmodule
`default_nettype wire
